// ===== amt_pkg.sv
// Package for the alarm mask and core trim register bank
package amt_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned TRIM_W = 8;
	localparam int unsigned OFS_W = 12;
	localparam int unsigned NUM_TT = 6;
	localparam logic [11:0] ADDR_ALARM_SUM = 12'h2C0;
	localparam logic [11:0] ADDR_ALARM_FLAGS = 12'h2C1;
	localparam logic [11:0] ADDR_ALARM_MASK = 12'h2C2;
	localparam logic [11:0] ADDR_MODE_CTRL = 12'h2C3;
	localparam logic [11:0] ADDR_INT_STATUS = 12'h2C4;
	localparam logic [11:0] ADDR_INT_MASK = 12'h2C5;
	localparam logic [11:0] ADDR_TT_A_DUAL = 12'h310;
	localparam logic [11:0] ADDR_TT_B_DUAL = 12'h313;
	localparam logic [11:0] ADDR_TT_A_IL_A = 12'h314;
	localparam logic [11:0] ADDR_TT_B_IL_A = 12'h315;
	localparam logic [11:0] ADDR_TT_A_IL_B = 12'h31A;
	localparam logic [11:0] ADDR_TT_B_IL_B = 12'h31B;
	localparam logic [11:0] ADDR_OFS_A_P0_A = 12'h344;
	localparam logic [7:0] ALARM_MASK_RST = 8'h05;
	localparam logic [7:0] ALARM_FLAGS_RST = 8'h05;
	localparam logic [7:0] ALARM_USED = 8'h05;
	localparam int unsigned BIT_DIVIDER_MISMATCH_FLAG = 0;
	localparam int unsigned BIT_REALIGN_ALM = 2;
	// Mode control bits
	localparam int unsigned BIT_INTERLEAVE = 0;
	localparam int unsigned BIT_FG_CAL = 1;
	localparam int unsigned BIT_IN_SEL = 2;
	localparam int unsigned BIT_PHASE90 = 3;
	localparam logic [3:0] MODE_RST = 4'h0;
	localparam logic [1:0] INT_RST = 2'h0;
	localparam logic [1:0] INT_MASK_RST = 2'h3;
	localparam int unsigned INT_REALIGN = 0;
	localparam int unsigned INT_DIVIDER = 1;
	localparam logic [7:0] TRIM_ZERO = 8'h00;
	localparam logic [11:0] OFS_ZERO = 12'h000;
	localparam logic [15:0] DATA_ZERO = 16'h0000;
endpackage : amt_pkg

// ===== amt_regs.sv
// Alarm mask and per-core trim register bank with alarm summary
//
// Summary of operation
// - Mask bit 2 set keeps realign alarm out of the summary bit.
// - Mask bit 0 set keeps clock-divider alarm out of the summary bit.
// - Alarm mask resets to 0x05; other bits are plain read/write.
// - Each 8-bit timing trim shifts its core's sampling instant.
// - Timing trims load fuse defaults after reset, not constants.
// - Software reads trims back and overwrites them; writes take effect.
// - Only the trim assigned to the current core and mode applies.
// - Dual mode: core A uses 0x310, core B uses 0x313.
// - Interleaved foreground cal: core A on first input uses 0x314.
// - Interleaved foreground cal: core B on first input uses 0x315.
// - Interleaved foreground cal: core A on second input uses 0x31A.
// - Interleaved foreground cal: core B on second input uses 0x31B.
// - Offset trim applies to core A, first input, 0 degree, fg cal only.
// - Offset trim defaults from fuses; top four bits are read/write.
// - Summary alarm reads 1 while any unmasked alarm flag is set.
// - Writing 1 to an alarm flag bit clears that flag.
// - Every alarm flag is set after reset or soft reset.
module amt_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [amt_pkg::ADDR_W-1:0] addr,
	input wire logic [amt_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [amt_pkg::DATA_W-1:0] rdata,
	input wire logic soft_reset,
	input wire logic fuse_valid,
	input wire logic [amt_pkg::TRIM_W*amt_pkg::NUM_TT-1:0] fuse_tt,
	input wire logic [amt_pkg::DATA_W-1:0] fuse_ofs,
	input wire logic realign_event,
	input wire logic divider_mismatch,
	output logic [amt_pkg::TRIM_W-1:0] core_a_trim,
	output logic [amt_pkg::TRIM_W-1:0] core_b_trim,
	output logic [amt_pkg::OFS_W-1:0] core_a_offset,
	output logic core_a_offset_en,
	output logic alarm_summary,
	output logic irq
);
	import amt_pkg::*;

	typedef enum logic [1:0] {
		AMT_LOAD = 2'b01,
		AMT_RUN = 2'b10
	} amt_state_e;

	amt_state_e state_r;
	logic [7:0] alarm_mask_reg_r;
	logic [7:0] alarm_flags_reg_r;
	logic [3:0] mode_r;
	logic [1:0] int_status_r;
	logic [1:0] int_mask_r;
	logic [TRIM_W-1:0] tt_r [NUM_TT];
	logic [DATA_W-1:0] ofs_r;
	logic [2:0] realign_sync_r;
	logic [2:0] divider_sync_r;
	logic realign_seen_r;
	logic divider_seen_r;
	logic [TRIM_W-1:0] trim_a_nxt;
	logic [TRIM_W-1:0] trim_b_nxt;
	logic realign_rise;
	logic divider_rise;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic [DATA_W-1:0] rd_nxt;
	logic wr_mask_hit;
	logic wr_mode_hit;
	logic wr_int_mask_hit;
	logic wr_flags_hit;
	logic wr_ofs_hit;
	logic rd_int_hit;
	logic offset_en_nxt;

	// Slots of the timing trim array, in fuse order
	localparam int unsigned TT_A_DUAL = 0;
	localparam int unsigned TT_B_DUAL = 1;
	localparam int unsigned TT_A_IL_A = 2;
	localparam int unsigned TT_B_IL_A = 3;
	localparam int unsigned TT_A_IL_B = 4;
	localparam int unsigned TT_B_IL_B = 5;

	localparam logic [11:0] TT_ADDR [NUM_TT] = '{ADDR_TT_A_DUAL,
		ADDR_TT_B_DUAL, ADDR_TT_A_IL_A, ADDR_TT_B_IL_A, ADDR_TT_A_IL_B,
		ADDR_TT_B_IL_B};

	// Strobe decode shared by the register blocks
	assign wr_mask_hit = wr && (addr == ADDR_ALARM_MASK);
	assign wr_mode_hit = wr && (addr == ADDR_MODE_CTRL);
	assign wr_int_mask_hit = wr && (addr == ADDR_INT_MASK);
	assign wr_flags_hit = wr && (addr == ADDR_ALARM_FLAGS);
	assign wr_ofs_hit = wr && (addr == ADDR_OFS_A_P0_A);
	assign rd_int_hit = rd && (addr == ADDR_INT_STATUS);

	// Fuse store may not be ready at reset release; wait for it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= AMT_LOAD;
		end else begin
			unique case (state_r)
				AMT_LOAD: begin
					if (fuse_valid) begin
						state_r <= AMT_RUN;
					end
				end
				AMT_RUN: begin
					if (soft_reset) begin
						state_r <= AMT_LOAD;
					end
				end
			endcase
		end
	end

	// Alarm sources are asynchronous; three stages, change when 2 and 3 agree
	// Idle level of both pins is low, so reset to zero gives no false edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			realign_sync_r <= 3'h0;
			realign_seen_r <= 1'b0;
		end else begin
			realign_sync_r <= {realign_sync_r[1:0], realign_event};
			if (realign_sync_r[1] == realign_sync_r[2]) begin
				realign_seen_r <= realign_sync_r[2];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divider_sync_r <= 3'h0;
			divider_seen_r <= 1'b0;
		end else begin
			divider_sync_r <= {divider_sync_r[1:0], divider_mismatch};
			if (divider_sync_r[1] == divider_sync_r[2]) begin
				divider_seen_r <= divider_sync_r[2];
			end
		end
	end

	// One pulse per settled rising edge; glitches shorter than two clocks die
	always_comb begin
		realign_rise = (realign_sync_r[1] == realign_sync_r[2]) &&
			realign_sync_r[2] && !realign_seen_r;
		divider_rise = (divider_sync_r[1] == divider_sync_r[2]) &&
			divider_sync_r[2] && !divider_seen_r;
	end

	always_comb begin
		flag_set = 8'h00;
		flag_set[BIT_REALIGN_ALM] = realign_rise;
		flag_set[BIT_DIVIDER_MISMATCH_FLAG] = divider_rise;
	end

	always_comb begin
		flag_clr = 8'h00;
		if (wr_flags_hit) begin
			flag_clr = wdata[7:0];
		end
	end

	// New event beats a clear in the same cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_flags_reg_r <= ALARM_FLAGS_RST;
		end else if (soft_reset) begin
			alarm_flags_reg_r <= ALARM_FLAGS_RST;
		end else begin
			alarm_flags_reg_r <= ((alarm_flags_reg_r & ~flag_clr) | flag_set)
				& ALARM_USED;
		end
	end

	// Reserved mask bits are kept as plain storage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_mask_reg_r <= ALARM_MASK_RST;
		end else if (wr_mask_hit) begin
			alarm_mask_reg_r <= wdata[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= MODE_RST;
		end else if (wr_mode_hit) begin
			mode_r <= wdata[3:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_mask_r <= INT_MASK_RST;
		end else if (wr_int_mask_hit) begin
			int_mask_r <= wdata[1:0];
		end
	end

	// Trims: fuse copy while loading, software writes afterwards
	generate
		for (genvar i = 0; i < NUM_TT; i++) begin : g_tt
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					tt_r[i] <= TRIM_ZERO;
				end else if (state_r == AMT_LOAD) begin
					tt_r[i] <= fuse_tt[i*TRIM_W +: TRIM_W];
				end else if (wr && addr == TT_ADDR[i]) begin
					tt_r[i] <= wdata[TRIM_W-1:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ofs_r <= DATA_ZERO;
		end else if (state_r == AMT_LOAD) begin
			ofs_r <= fuse_ofs;
		end else if (wr_ofs_hit) begin
			ofs_r <= wdata;
		end
	end

	// Trim selection by mode, core and input
	always_comb begin
		if (!mode_r[BIT_INTERLEAVE]) begin
			trim_a_nxt = tt_r[TT_A_DUAL];
			trim_b_nxt = tt_r[TT_B_DUAL];
		end else if (!mode_r[BIT_IN_SEL]) begin
			trim_a_nxt = tt_r[TT_A_IL_A];
			trim_b_nxt = tt_r[TT_B_IL_A];
		end else begin
			trim_a_nxt = tt_r[TT_A_IL_B];
			trim_b_nxt = tt_r[TT_B_IL_B];
		end
		// Non-fg interleave trims live elsewhere; hold dual values
		if (mode_r[BIT_INTERLEAVE] && !mode_r[BIT_FG_CAL]) begin
			trim_a_nxt = tt_r[TT_A_DUAL];
			trim_b_nxt = tt_r[TT_B_DUAL];
		end
	end

	// Offset only for the one case it was trimmed in
	always_comb begin
		offset_en_nxt = mode_r[BIT_INTERLEAVE] && mode_r[BIT_FG_CAL]
			&& !mode_r[BIT_IN_SEL] && !mode_r[BIT_PHASE90];
	end

	// Outputs registered: a write lands one clock after the register update
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			core_a_trim <= TRIM_ZERO;
			core_b_trim <= TRIM_ZERO;
		end else begin
			core_a_trim <= trim_a_nxt;
			core_b_trim <= trim_b_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			core_a_offset <= OFS_ZERO;
			core_a_offset_en <= 1'b0;
		end else begin
			core_a_offset <= ofs_r[OFS_W-1:0];
			core_a_offset_en <= offset_en_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			alarm_summary <= 1'b0;
		end else begin
			alarm_summary <= |(alarm_flags_reg_r & ~alarm_mask_reg_r
				& ALARM_USED);
		end
	end

	// Interrupt status: sticky, read clears, event wins over clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_status_r <= INT_RST;
		end else begin
			int_status_r <= (rd_int_hit ? INT_RST :
				int_status_r) | {divider_rise, realign_rise};
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status_r & ~int_mask_r);
		end
	end

	always_comb begin
		rd_nxt = DATA_ZERO;
		unique case (addr)
			ADDR_ALARM_SUM: begin
				rd_nxt[0] = alarm_summary;
			end
			ADDR_ALARM_FLAGS: begin
				rd_nxt[7:0] = alarm_flags_reg_r;
			end
			ADDR_ALARM_MASK: begin
				rd_nxt[7:0] = alarm_mask_reg_r;
			end
			ADDR_MODE_CTRL: begin
				rd_nxt[3:0] = mode_r;
			end
			ADDR_INT_STATUS: begin
				rd_nxt[1:0] = int_status_r;
			end
			ADDR_INT_MASK: begin
				rd_nxt[1:0] = int_mask_r;
			end
			ADDR_TT_A_DUAL: begin
				rd_nxt[7:0] = tt_r[TT_A_DUAL];
			end
			ADDR_TT_B_DUAL: begin
				rd_nxt[7:0] = tt_r[TT_B_DUAL];
			end
			ADDR_TT_A_IL_A: begin
				rd_nxt[7:0] = tt_r[TT_A_IL_A];
			end
			ADDR_TT_B_IL_A: begin
				rd_nxt[7:0] = tt_r[TT_B_IL_A];
			end
			ADDR_TT_A_IL_B: begin
				rd_nxt[7:0] = tt_r[TT_A_IL_B];
			end
			ADDR_TT_B_IL_B: begin
				rd_nxt[7:0] = tt_r[TT_B_IL_B];
			end
			ADDR_OFS_A_P0_A: begin
				rd_nxt = ofs_r;
			end
			default: begin
				rd_nxt = DATA_ZERO;
			end
		endcase
	end

	// Read data only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= DATA_ZERO;
		end else if (rd) begin
			rdata <= rd_nxt;
		end else begin
			rdata <= DATA_ZERO;
		end
	end
endmodule : amt_regs

// ===== amt_regs_sva.sv
// Checker for the alarm mask and trim register bank
module amt_regs_sva
	import amt_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic soft_reset,
	input wire logic fuse_valid,
	input wire logic realign_event,
	input wire logic divider_mismatch,
	input wire logic [7:0] core_a_trim,
	input wire logic core_a_offset_en,
	input wire logic alarm_summary,
	input wire logic irq
);
	logic [7:0] msk_r;
	logic [3:0] mode_r;
	logic run_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) msk_r <= ALARM_MASK_RST;
		else if (wr && addr == ADDR_ALARM_MASK) msk_r <= wdata[7:0];
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) mode_r <= MODE_RST;
		else if (wr && addr == ADDR_MODE_CTRL) mode_r <= wdata[3:0];
	end
	// Lags fuse_valid: trims only stick one edge after it
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) run_r <= 1'h0;
		else run_r <= fuse_valid && !soft_reset;
	end
	rd_idle_a:
	assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside answer cycle");
	sum_mask_a:
	assert property ($past(msk_r[0] & msk_r[2]) |-> !alarm_summary)
		else $error("masked alarm reached summary");
	realign_a:
	assert property ($rose(realign_event) && !msk_r[2]
		|-> ##[2:8] alarm_summary) else $error("realign alarm lost");
	divider_a:
	assert property ($rose(divider_mismatch) && !msk_r[0]
		|-> ##[2:8] alarm_summary) else $error("divider alarm lost");
	flag_clr_a:
	assert property (wr && addr == ADDR_ALARM_FLAGS && wdata[0] && wdata[2]
		|-> ##2 !alarm_summary) else $error("flags not cleared");
	soft_a:
	assert property (soft_reset && !msk_r[0] |-> ##2 alarm_summary)
		else $error("soft reset left flags clear");
	trim_a:
	assert property (wr && addr == ADDR_TT_A_DUAL && run_r
		&& mode_r[1:0] != 2'h3 |=> ##1 core_a_trim == $past(wdata[7:0], 2))
		else $error("dual trim not applied");
	offset_a:
	assert property (mode_r == $past(mode_r) && mode_r == $past(mode_r, 2)
		|-> core_a_offset_en == (mode_r == 4'h3))
		else $error("offset enable wrong for mode");
	irq_clr_a:
	assert property (rd && addr == ADDR_INT_STATUS |-> ##2 !irq)
		else $error("irq held after status read");
endmodule : amt_regs_sva

bind amt_regs amt_regs_sva u_amt_regs_sva (.clk, .rst_b, .addr, .wdata,
	.wr, .rd, .rdata, .soft_reset, .fuse_valid, .realign_event,
	.divider_mismatch, .core_a_trim, .core_a_offset_en, .alarm_summary,
	.irq);

// ===== tb_amt_regs.sv
// Self-checking bench for the alarm mask and trim register bank
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: %h not %h", $time, g, e); end end
module tb_amt_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import amt_pkg::*;
	logic clk, rst_b, wr, rd, soft_reset, fuse_valid, realign_event;
	logic divider_mismatch, core_a_offset_en, alarm_summary, irq;
	logic [11:0] addr, core_a_offset;
	logic [15:0] wdata, rdata, fuse_ofs;
	logic [47:0] fuse_tt;
	logic [7:0] core_a_trim, core_b_trim;
	int fail_count, cmp_count, cyc;
	logic [11:0] ta [6] = '{ADDR_TT_A_DUAL, ADDR_TT_B_DUAL, ADDR_TT_A_IL_A,
		ADDR_TT_B_IL_A, ADDR_TT_A_IL_B, ADDR_TT_B_IL_B};
	amt_regs u_amt_regs (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
		.soft_reset, .fuse_valid, .fuse_tt, .fuse_ofs, .realign_event,
		.divider_mismatch, .core_a_trim, .core_b_trim, .core_a_offset,
		.core_a_offset_en, .alarm_summary, .irq);
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	task w(input int n);
		repeat (n) @(posedge clk);
	endtask : w
	task wr_t(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : wr_t
	task rd_chk(input logic [11:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1 `CHK(rdata, e)
	endtask : rd_chk
	// Long pulse so the synchroniser surely sees it
	task ev_t(input logic r);
		@(posedge clk);
		if (r) realign_event <= 1'h1;
		else divider_mismatch <= 1'h1;
		w(8);
		realign_event <= 1'h0;
		divider_mismatch <= 1'h0;
		w(4);
	endtask : ev_t
	task t_reset();
		wr_t(ADDR_TT_A_DUAL, 16'h00EE);
		fuse_valid <= 1'h1;
		w(2);
		rd_chk(ADDR_ALARM_MASK, 16'h0005);
		for (int i = 0; i < 6; i++)
			rd_chk(ta[i], {8'h00, fuse_tt[i*8 +: 8]});
		rd_chk(ADDR_OFS_A_P0_A, 16'hA123);
		rd_chk(12'h3FF, 16'h0000);
	endtask : t_reset
	task automatic t_trim();
		logic [3:0] md [4] = '{4'h0, 4'h1, 4'h3, 4'h7};
		logic [7:0] ia [4] = '{8'h00, 8'h00, 8'h02, 8'h04};
		for (int i = 0; i < 6; i++)
			wr_t(ta[i], 16'h00A0 + 16'(i));
		for (int i = 0; i < 6; i++)
			rd_chk(ta[i], 16'h00A0 + 16'(i));
		wr_t(ADDR_OFS_A_P0_A, 16'hF456);
		rd_chk(ADDR_OFS_A_P0_A, 16'hF456);
		for (int i = 0; i < 4; i++) begin
			wr_t(ADDR_MODE_CTRL, {12'h000, md[i]});
			w(3);
			`CHK(core_a_trim, 8'hA0 + ia[i])
			`CHK(core_b_trim, 8'hA1 + ia[i])
			`CHK(core_a_offset_en, md[i] == 4'h3)
		end
		`CHK(core_a_offset, 12'h456)
		wr_t(ADDR_MODE_CTRL, 16'h0000);
	endtask : t_trim
	task t_alarm();
		wr_t(ADDR_ALARM_MASK, 16'h00F8);
		rd_chk(ADDR_ALARM_MASK, 16'h00F8);
		`CHK(alarm_summary, 1'h1)
		rd_chk(ADDR_ALARM_SUM, 16'h0001);
		wr_t(ADDR_ALARM_FLAGS, 16'h0005);
		rd_chk(ADDR_ALARM_FLAGS, 16'h0000);
		wr_t(ADDR_ALARM_MASK, 16'h0004);
		ev_t(1'h1);
		`CHK(alarm_summary, 1'h0)
		ev_t(1'h0);
		`CHK(alarm_summary, 1'h1)
		wr_t(ADDR_ALARM_MASK, 16'h0001);
		wr_t(ADDR_ALARM_FLAGS, 16'h0005);
		ev_t(1'h1);
		`CHK(alarm_summary, 1'h1)
		wr_t(ADDR_ALARM_MASK, 16'h0005);
		w(2);
		`CHK(alarm_summary, 1'h0)
		wr_t(ADDR_INT_MASK, 16'h0001);
		w(2);
		`CHK(irq, 1'h1)
		wr_t(ADDR_INT_MASK, 16'h0003);
		w(2);
		`CHK(irq, 1'h0)
		wr_t(ADDR_INT_MASK, 16'h0000);
		rd_chk(ADDR_INT_STATUS, 16'h0003);
		rd_chk(ADDR_INT_STATUS, 16'h0000);
		`CHK(irq, 1'h0)
		wr_t(ADDR_ALARM_FLAGS, 16'h0005);
		wr_t(ADDR_ALARM_MASK, 16'h0000);
		@(posedge clk) soft_reset <= 1'h1;
		@(posedge clk) soft_reset <= 1'h0;
		w(2);
		rd_chk(ADDR_ALARM_FLAGS, 16'h0005);
		rd_chk(ADDR_TT_A_DUAL, 16'h0011);
	endtask : t_alarm
	initial begin
		rst_b = 1'h0;
		{wr, rd, soft_reset, fuse_valid, realign_event, divider_mismatch} = '0;
		addr = 12'h000;
		wdata = 16'h0000;
		fuse_tt = 48'h6655_4433_2211;
		fuse_ofs = 16'hA123;
		w(16);
		rst_b <= 1'h1;
		t_reset();
		t_trim();
		t_alarm();
		report_and_stop();
	end
endmodule : tb_amt_regs
